// ==== verilog/rnv_defines.vh ====
`ifndef RNV_DEFINES_VH
`define RNV_DEFINES_VH
// Mode bit positions in the channel configuration word
`define RNV_CFG_RECOVERY_BIT 0
`define RNV_CFG_CODE_BIT 3
`define RNV_CFG_DUAL_BIT 4
`define RNV_CFG_WIDTH 8
`define RNV_CFG_RESET 8'h00
// Output modes
`define RNV_MODE_DUAL 2'h0
`define RNV_MODE_SLICE 2'h1
`define RNV_MODE_SINGLE 2'h2
// Field positions inside one buffered word
`define RNV_WORD_POS_BIT 3
`define RNV_WORD_NEG_BIT 2
`define RNV_WORD_NRZ_BIT 1
`define RNV_WORD_FLAG_BIT 0
`define RNV_WORD_WIDTH 4
// Reset level of every receive output
`define RNV_OUT_RESET 1'b0
// Fifo geometry
`define RNV_FIFO_DEPTH 16
`define RNV_FIFO_AW 4
`endif

// ==== verilog/rnv_fifo.v ====
`default_nettype none
module rnv_fifo #(
  parameter WIDTH = 4,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Write side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Read side
  output reg out_valid_o,
  input wire out_ready_i,
  output reg [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  localparam [AW:0] FULL_FILL = DEPTH;
  wire [AW:0] fill = wr_q - rd_q;
  wire full = (fill == FULL_FILL);
  wire empty = (fill == {(AW+1){1'b0}});
  // Output register refills when empty or taken
  wire pop = !empty && (!out_valid_o || out_ready_i);
  wire push = in_valid_i && !full;
  assign in_ready_o = !full;
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
        out_data_o <= mem_q[rd_q[AW-1:0]];
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule // rnv_fifo
`default_nettype wire

// ==== verilog/rnv_rx_neg_mux.v ====
// Contract
// - Dual rail with recovery: negative NRZ data out
// - Recovery off: raw sliced negative data out
// - Single rail, code bit set: flag code violations
// - Single rail, code bit clear: flag bipolar violations
// - Single rail: positive pin carries NRZ data
`include "rnv_defines.vh"
`default_nettype none
module rnv_rx_neg_mux #(
  parameter DEPTH = `RNV_FIFO_DEPTH,
  parameter AW = `RNV_FIFO_AW
) (
  // Clock and reset (recovered receive clock)
  input wire clk_i,
  input wire nrst_i,
  // Configuration word of this channel
  input wire [`RNV_CFG_WIDTH-1:0] cfg_i,
  // Recovered bit stream from clock recovery
  input wire bit_valid_i,
  output wire bit_ready_o,
  input wire rx_pos_nrz_i,
  input wire rx_neg_nrz_i,
  input wire rx_nrz_i,
  input wire code_viol_i,
  input wire bipolar_viol_i,
  // Raw sliced front-end pulses (asynchronous)
  input wire slice_pos_i,
  input wire slice_neg_i,
  // Toward terminal equipment
  input wire te_ready_i,
  output reg rx_positive_rail_out_o,
  output reg rx_negative_rail_out_o,
  output reg out_valid_o
);
  localparam WORD_W = `RNV_WORD_WIDTH;

  // Recovery off wins over the dual-rail bit
  function [1:0] mode_of;
    input recov;
    input dual;
    begin
      if (!recov)
        mode_of = `RNV_MODE_SLICE;
      else if (dual)
        mode_of = `RNV_MODE_DUAL;
      else
        mode_of = `RNV_MODE_SINGLE;
    end
  endfunction

  // Which violation the flag reports, picked by the line-code bit
  function flag_of;
    input sel;
    input code_v;
    input bipolar_v;
    begin
      if (sel)
        flag_of = code_v;
      else
        flag_of = bipolar_v;
    end
  endfunction

  // Mode bits of the channel configuration word
  wire recovery_enable;
  wire dual_sel;
  wire code_sel;
  assign recovery_enable = cfg_i[`RNV_CFG_RECOVERY_BIT];
  assign dual_sel = cfg_i[`RNV_CFG_DUAL_BIT];
  assign code_sel = cfg_i[`RNV_CFG_CODE_BIT];

  // Raw slicer pulses come from the analog front end, not from the
  // recovered clock, so each one passes two flip-flops first
  wire [1:0] slice_raw;
  wire [1:0] slice_sync;
  assign slice_raw = {slice_pos_i, slice_neg_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      reg meta_q;
      reg stable_q;
      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= slice_raw[gi];
          stable_q <= meta_q;
        end
      end
      assign slice_sync[gi] = stable_q;
    end
  endgenerate

  // Mode follows the configuration word at output time
  wire [1:0] mode;
  assign mode = mode_of(recovery_enable, dual_sel);

  // Each stored word keeps data and its violation flag together so the
  // flag stays aligned with its bit through the buffer
  wire rx_violation_flag;
  wire [WORD_W-1:0] wr_word;
  assign rx_violation_flag = flag_of(code_sel, code_viol_i, bipolar_viol_i);
  assign wr_word[`RNV_WORD_POS_BIT] = rx_pos_nrz_i;
  assign wr_word[`RNV_WORD_NEG_BIT] = rx_neg_nrz_i;
  assign wr_word[`RNV_WORD_NRZ_BIT] = rx_nrz_i;
  assign wr_word[`RNV_WORD_FLAG_BIT] = rx_violation_flag;

  // Fields of the word at the head of the buffer
  wire rd_valid;
  wire [WORD_W-1:0] rd_word;
  wire rd_pos;
  wire rd_neg;
  wire rd_nrz;
  wire rd_flag;
  assign rd_pos = rd_word[`RNV_WORD_POS_BIT];
  assign rd_neg = rd_word[`RNV_WORD_NEG_BIT];
  assign rd_nrz = rd_word[`RNV_WORD_NRZ_BIT];
  assign rd_flag = rd_word[`RNV_WORD_FLAG_BIT];

  // Sliced mode bypasses the buffer, so its stream never stalls and
  // whatever is still buffered is thrown away
  wire drain;
  assign drain = te_ready_i || (mode == `RNV_MODE_SLICE);

  // Depth bounds how long the terminal may stall before the recovered
  // stream is refused; one more word waits in the buffer's out register
  rnv_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(bit_valid_i),
    .in_ready_o(bit_ready_o),
    .in_data_i(wr_word),
    .out_valid_o(rd_valid),
    .out_ready_i(drain),
    .out_data_o(rd_word)
  );

  // A word moves only in a cycle the terminal accepts it
  wire take;
  assign take = rd_valid && te_ready_i;

  reg pos_d;
  reg neg_d;
  reg vld_d;

  // Rails hold their last delivered bit between takes; the flag does not
  always @* begin
    pos_d = rx_positive_rail_out_o;
    neg_d = rx_negative_rail_out_o;
    vld_d = 1'b0;
    case (mode)
      `RNV_MODE_SLICE: begin
        pos_d = slice_sync[1];
        neg_d = slice_sync[0];
        vld_d = 1'b1;
      end
      `RNV_MODE_DUAL: begin
        if (take) begin
          pos_d = rd_pos;
          neg_d = rd_neg;
        end
        vld_d = take;
      end
      `RNV_MODE_SINGLE: begin
        if (take) begin
          pos_d = rd_nrz;
        end
        // Flag lasts exactly the one clock its bit is handed over
        neg_d = take & rd_flag;
        vld_d = take;
      end
      default: begin
        // Unused mode code: park every output low
        pos_d = `RNV_OUT_RESET;
        neg_d = `RNV_OUT_RESET;
        vld_d = `RNV_OUT_RESET;
      end
    endcase
  end

  // Words still buffered when the mode changes leave in the format of
  // the new mode; change modes only once the buffer has drained
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_positive_rail_out_o <= `RNV_OUT_RESET;
    end else begin
      rx_positive_rail_out_o <= pos_d;
    end
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_negative_rail_out_o <= `RNV_OUT_RESET;
    end else begin
      rx_negative_rail_out_o <= neg_d;
    end
  end

  // Slice mode: pin to output takes two synchroniser stages plus this
  // flop, three clocks in all
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_valid_o <= `RNV_OUT_RESET;
    end else begin
      out_valid_o <= vld_d;
    end
  end
endmodule // rnv_rx_neg_mux
`default_nettype wire

// ==== dv/rnv_props.sv ====
`default_nettype none
module rnv_props (
  input wire logic clk_i, nrst_i, slice_pos_i, slice_neg_i, out_valid_o,
  input wire logic [7:0] cfg_i,
  input wire logic rx_positive_rail_out_o, rx_negative_rail_out_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire logic ng = rx_negative_rail_out_o;
  wire logic ps = rx_positive_rail_out_o;
  wire logic sg = cfg_i[0] & !cfg_i[4];
  wire logic du = cfg_i[0] & cfg_i[4];
  wire logic sl = !cfg_i[0];
  // Slicer path skips the fifo, so its latency is fixed
  a_slice_neg: assert property (sl[*4] |-> ng == $past(slice_neg_i, 3))
    else $error("slice neg");
  a_slice_pos: assert property (sl[*4] |-> ps == $past(slice_pos_i, 3))
    else $error("slice pos");
  a_slice_vld: assert property (sl[*4] |-> out_valid_o)
    else $error("slice valid");
  a_flag_idle: assert property (sg[*2] ##0 !out_valid_o |-> !ng)
    else $error("flag idle");
  a_dual_hold: assert property (du[*2] ##0 !out_valid_o |-> $stable(ng))
    else $error("dual hold");
  a_rail_hold: assert property (sg[*2] ##0 !out_valid_o |-> $stable(ps))
    else $error("rail hold");
  c_flag: cover property (sg && out_valid_o && ng);
  c_dual: cover property (du && out_valid_o && ng);
  c_slice: cover property (sl && ng);
endmodule // rnv_props
`default_nettype wire

// ==== dv/rnv_te_model.sv ====
`default_nettype none
module rnv_te_model (
  input wire logic clk_i,
  input wire logic hold_i,
  output logic te_ready_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int s = 96999;
  // Random stalls keep backpressure through the fifo busy
  always @(negedge clk_i) te_ready_o <= !hold_i && $random(s) % 3 != 0;
endmodule // rnv_te_model
`default_nettype wire

// ==== dv/rnv_rx_neg_mux_tb.sv ====
`default_nettype none
module rnv_rx_neg_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, nrst_i = 0, bv = 0, hd = 1;
  logic [4:0] d = 0;
  logic [1:0] sl = 0;
  logic [7:0] cf = 8'h11;
  logic [5:0] sh = 0;
  wire logic rdy, te, ov;
  wire logic [1:0] o;
  int err_total, comparisons, seed = 96999, cyc;
  logic [1:0] q[$];
  always #25 clk_i = ~clk_i;
  rnv_rx_neg_mux u_rnv_rx_neg_mux (.clk_i, .nrst_i, .cfg_i(cf),
    .bit_valid_i(bv), .bit_ready_o(rdy), .rx_pos_nrz_i(d[4]),
    .rx_neg_nrz_i(d[3]), .rx_nrz_i(d[2]), .code_viol_i(d[1]),
    .bipolar_viol_i(d[0]), .slice_pos_i(sl[1]), .slice_neg_i(sl[0]),
    .te_ready_i(te), .rx_positive_rail_out_o(o[1]),
    .rx_negative_rail_out_o(o[0]), .out_valid_o(ov));
  rnv_te_model u_rnv_te_model (.clk_i, .hold_i(hd), .te_ready_o(te));
  task chk(input logic [1:0] g, e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Dual rail expects both data rails, single rail NRZ plus chosen flag
  function automatic logic [1:0] exp_of(input logic [7:0] c,
                                        input logic [4:0] w);
    return c[4] ? w[4:3] : {w[2], c[3] ? w[1] : w[0]};
  endfunction
  task send(input int k);
    repeat (k) begin
      @(negedge clk_i);
      d = 5'($random(seed));
      bv = 1;
      while (rdy !== 1'b1) @(negedge clk_i);
      q.push_back(exp_of(cf, d));
    end
    @(negedge clk_i) bv = 0;
    repeat (200) @(negedge clk_i);
  endtask
  always @(negedge clk_i)
    if (cf[0] && ov === 1'b1)
      chk(o, q.size() ? q.pop_front() : 2'hX);
  always @(posedge clk_i)
    if (++cyc > 3000) begin
      err_total++;
      give_verdict;
    end
  initial begin
    repeat (20) @(negedge clk_i);
    nrst_i = 1;
    fork
      send(24);
      begin
        repeat (30) @(negedge clk_i);
        chk({1'b0, rdy}, 2'h0);
        hd <= 0;
      end
    join
    cf = 8'h09;
    send(40);
    cf = 8'h01;
    send(40);
    chk({1'b0, q.size() != 0}, 2'h0);
    cf = 8'h00;
    repeat (60) begin
      @(negedge clk_i);
      chk(o, sh[5:4]);
      chk({1'b0, ov}, 2'h1);
      sl = 2'($random(seed));
      sh = {sh[3:0], sl};
    end
    give_verdict;
  end
endmodule // rnv_rx_neg_mux_tb
bind rnv_rx_neg_mux rnv_props u_rnv_props (.clk_i, .nrst_i, .slice_pos_i,
  .slice_neg_i, .out_valid_o, .cfg_i, .rx_positive_rail_out_o,
  .rx_negative_rail_out_o);
`default_nettype wire
